// ===== core/afd_top.sv
// adaptive temporal and spatial dither, before and after the white-balance table
// assumes the table outside answers combinationally to table_addr_q
//
// What this block does
// R1: dithered pixels leave as six bits per channel
// R2: increments toggle across frames for temporal averaging
// R3: increments spread over pixel group, combined spatially
// R4: nine-bit expansion reproduces full 24-bit colour range
// R5: low output bits driven zero while dithering
// R6: dithering enabled only through control register
// R7: two instances, each with its own enable
// R8: pre-table instance feeds the six-bit table input
// R9: post-table instance reduces table output to six
// R10: host programs sync or data-enable-only timing mode
// R11: host programs polarity of each timing signal
// R12: widen eight-bit channel to nine bits first
// R13: pick one of four algorithms, default mostly
// R14: black, white, full on/off use special algorithms
// R15: pattern one adds one, zero leaves unchanged
// R16: three discarded low bits select the pattern
// R17: default 001 pattern, four per thirty-two positions
// R18: frame, line, pixel counters index the pattern
// R19: host enables post-table instance for six-bit sources
`timescale 1ns/1ps
module afd_top
  import afd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire afd_pkg::afd_pix_type in_pix,
  output afd_pkg::afd_pix_type   table_addr_q,
  input  wire afd_pkg::afd_pix_type table_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output afd_pkg::afd_pix_type   out_pix
);
  import afd_pkg::*;

  // ------------------------------------------------------------
  // dither arithmetic
  // ------------------------------------------------------------
  function automatic logic [8:0] widen(input logic [7:0] v);
    widen = {v, v[7]}; // R12 R4
  endfunction

  function automatic afd_alg_type pick_alg(input afd_pix_type p, input logic [7:0] v);
    logic mono;
    mono = ({p.r, p.g, p.b} == 24'h000000) || ({p.r, p.g, p.b} == 24'hFFFFFF);
    if (mono) begin
      pick_alg = ALG_MONO; // R14
    end else if (v[7:2] == 6'h3F) begin
      pick_alg = ALG_SAT; // R14
    end else if (v[7:2] == 6'h00) begin
      pick_alg = ALG_DARK; // R14
    end else begin
      pick_alg = ALG_DEFAULT; // R13
    end
  endfunction

  function automatic logic [7:0] dither_ch(input afd_pix_type p, input logic [7:0] v,
                                           input afd_pos_type pos, input logic is_g);
    logic [8:0]  wide;
    logic [2:0]  k;
    logic [2:0]  rank;
    logic [6:0]  idx;
    logic        inc;
    afd_alg_type alg;
    wide = widen(v);
    k    = wide[2:0]; // R16
    alg  = pick_alg(p, v);
    idx  = {pos.frame, pos.line, pos.pixel};
    rank = 3'(pos.pixel + 3'(3 * pos.line) + 3'(5 * pos.frame) + (is_g ? 3'h2 : 3'h0));
    inc  = 1'b0;
    unique case (alg)
      ALG_DEFAULT: begin
        if (k == 3'h1) begin
          inc = is_g ? PAT_G[idx] : PAT_RB[idx]; // R17 R2 R3
        end else begin
          inc = (rank < k); // R2 R3
        end
      end
      ALG_DARK: begin
        // spatial only: no frame flicker near black
        inc = (3'(pos.pixel + 3'(3 * pos.line) + (is_g ? 3'h2 : 3'h0)) < k);
      end
      ALG_MONO: inc = 1'b0;
      ALG_SAT:  inc = 1'b0; // avoids wrap past full scale
    endcase
    dither_ch = {wide[8:3] + 6'(inc), 2'b00}; // R15 R1
  endfunction

  function automatic afd_pix_type dither_pix(input afd_pix_type p, input afd_pos_type pos);
    dither_pix   = p;
    dither_pix.r = dither_ch(p, p.r, pos, 1'b0);
    dither_pix.g = dither_ch(p, p.g, pos, 1'b1);
    dither_pix.b = dither_ch(p, p.b, pos, 1'b0);
  endfunction

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic              ack_q;
  logic              req;
  afd_pos_type       pos_q;
  logic              fifo_rd_valid;

  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
    end else if (avs_write && ack_q && avs_address == OFS_CTRL) begin
      ctrl_q <= avs_writedata[CTRL_W-1:0]; // R6 R10 R11
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      unique case (avs_address)
        OFS_CTRL:   avs_readdata <= {26'h0, ctrl_q};
        OFS_STATUS: avs_readdata <= {24'h0, fifo_rd_valid, pos_q};
        default:    avs_readdata <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // input buffer and pipeline control
  // ------------------------------------------------------------
  afd_pix_type fifo_rd_data;
  logic        s1_valid_q;
  logic        adv;
  logic        pop;

  assign adv = !out_valid || out_ready;
  assign pop = fifo_rd_valid && adv;

  afd_fifo #(
    .W (PIX_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .wr_data  (in_pix),
    .rd_valid (fifo_rd_valid),
    .rd_ready (adv),
    .rd_data  (fifo_rd_data)
  );

  // ------------------------------------------------------------
  // position counters
  // ------------------------------------------------------------
  logic       hs_act;
  logic       vs_act;
  logic       de_act;
  logic       hs_prev_q;
  logic       vs_prev_q;
  logic       de_prev_q;
  logic [7:0] gap_q;
  logic       frame_edge;
  logic       line_edge;

  assign hs_act = fifo_rd_data.hs == ctrl_q[BIT_HS_POL]; // R11
  assign vs_act = fifo_rd_data.vs == ctrl_q[BIT_VS_POL]; // R11
  assign de_act = fifo_rd_data.de == ctrl_q[BIT_DE_POL]; // R11

  always_comb begin
    if (ctrl_q[BIT_DE_ONLY]) begin
      // frame start: active video after a long blank run
      frame_edge = de_act && !de_prev_q && (gap_q >= VBLANK_GAP); // R10
      line_edge  = !de_act && de_prev_q; // R10
    end else begin
      frame_edge = vs_act && !vs_prev_q; // R10
      line_edge  = hs_act && !hs_prev_q; // R10
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
      de_prev_q <= 1'b0;
      gap_q     <= '0;
    end else if (pop) begin
      hs_prev_q <= hs_act;
      vs_prev_q <= vs_act;
      de_prev_q <= de_act;
      if (de_act) begin
        gap_q <= '0;
      end else if (gap_q != 8'hFF) begin
        gap_q <= gap_q + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_q <= '0;
    end else if (pop) begin
      if (frame_edge) begin
        pos_q.frame <= pos_q.frame + 2'h1; // R18
        pos_q.line  <= '0;
        pos_q.pixel <= de_act ? 3'h1 : 3'h0;
      end else if (line_edge) begin
        pos_q.line  <= pos_q.line + 2'h1; // R18
        pos_q.pixel <= '0;
      end else if (de_act) begin
        pos_q.pixel <= pos_q.pixel + 3'h1; // R18
      end
    end
  end

  // ------------------------------------------------------------
  // stage 1: pre-table dither, drives the table address
  // ------------------------------------------------------------
  afd_pos_type s1_pos_q;
  afd_pos_type cur_pos;

  assign cur_pos = frame_edge ? afd_pos_type'{frame: pos_q.frame + 2'h1, line: 2'h0, pixel: 3'h0}
                              : pos_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_valid_q   <= 1'b0;
      table_addr_q <= '0;
      s1_pos_q     <= '0;
    end else if (adv) begin
      s1_valid_q <= fifo_rd_valid;
      if (fifo_rd_valid) begin
        s1_pos_q <= cur_pos;
        if (ctrl_q[BIT_PRE_EN] && de_act) begin
          table_addr_q <= dither_pix(fifo_rd_data, cur_pos); // R8 R7
        end else begin
          table_addr_q <= fifo_rd_data;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // stage 2: post-table dither to the display
  // ------------------------------------------------------------
  logic s1_de_act;
  assign s1_de_act = table_data.de == ctrl_q[BIT_DE_POL];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
    end else if (adv) begin
      out_valid <= s1_valid_q;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_pix <= '0;
    end else if (adv && s1_valid_q) begin
      if (ctrl_q[BIT_POST_EN] && s1_de_act) begin
        out_pix <= dither_pix(table_data, s1_pos_q); // R9 R7
      end else if (ctrl_q[BIT_PRE_EN] || ctrl_q[BIT_POST_EN]) begin
        // any enabled instance keeps the two low bits idle, blanking included
        out_pix   <= table_data;
        out_pix.r <= {table_data.r[7:2], 2'b00}; // R5
        out_pix.g <= {table_data.g[7:2], 2'b00}; // R5
        out_pix.b <= {table_data.b[7:2], 2'b00}; // R5
      end else begin
        out_pix <= table_data;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_out_low_zero : assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
    out_valid && (ctrl_q[BIT_PRE_EN] || ctrl_q[BIT_POST_EN]) && $stable(ctrl_q)
      |-> {out_pix.r[1:0], out_pix.g[1:0], out_pix.b[1:0]} == 6'h00)
    else $error("low output bits active while dithering");

  a_pre_low_zero : assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
    $past(adv && fifo_rd_valid && ctrl_q[BIT_PRE_EN] && de_act)
      |-> {table_addr_q.r[1:0], table_addr_q.g[1:0], table_addr_q.b[1:0]} == 6'h00)
    else $error("table address not six bit");

  a_inc_one_max : assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
    $past(adv && s1_valid_q && ctrl_q[BIT_POST_EN] && s1_de_act)
      |-> (out_pix.g[7:2] == $past(table_data.g[7:2]))
       || (out_pix.g[7:2] == $past(table_data.g[7:2]) + 6'h01))
    else $error("increment other than zero or one");

  a_mono_pass : assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
    $past(adv && s1_valid_q && ctrl_q[BIT_POST_EN] && s1_de_act
          && {table_data.r, table_data.g, table_data.b} == 24'hFFFFFF)
      |-> {out_pix.r, out_pix.g, out_pix.b} == 24'hFCFCFC)
    else $error("white pixel dithered");

  a_bypass_both : assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    $past(adv && s1_valid_q && {ctrl_q[BIT_POST_EN], ctrl_q[BIT_PRE_EN]} == 2'b00)
      |-> out_pix == $past(table_data))
    else $error("pixel altered with both instances off");

  a_frame_step : assert property (@(posedge sys_clk) disable iff (sys_rst) // R18
    pop && frame_edge |=> pos_q.frame == $past(pos_q.frame) + 2'h1 && pos_q.line == 2'h0)
    else $error("frame counter did not advance");

  a_line_step : assert property (@(posedge sys_clk) disable iff (sys_rst) // R18
    pop && line_edge && !frame_edge |=> pos_q.line == $past(pos_q.line) + 2'h1 && pos_q.pixel == 3'h0)
    else $error("line counter did not advance");

  a_bus_answer : assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
    req && avs_waitrequest && !ack_q |=> !avs_waitrequest || !req)
    else $error("bus answer later than one cycle");

  a_ctrl_write : assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
    avs_write && !avs_waitrequest && avs_address == OFS_CTRL
      |=> ctrl_q == $past(avs_writedata[CTRL_W-1:0]))
    else $error("control write lost");

endmodule // afd_top

// ===== inc/afd_pkg.sv
// shared constants and carrier types of the adaptive dither block
// assumes one 20 MHz clock and an avalon-mm register port
package afd_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_STATUS  = 4'h4;
  localparam int          BIT_PRE_EN  = 0;
  localparam int          BIT_POST_EN = 1;
  localparam int          BIT_DE_ONLY = 2;
  localparam int          BIT_HS_POL  = 3;
  localparam int          BIT_VS_POL  = 4;
  localparam int          BIT_DE_POL  = 5;
  localparam int          CTRL_W      = 6;
  localparam logic [5:0]  CTRL_RST    = 6'h38;

  // ------------------------------------------------------------
  // timing and sizes
  // ------------------------------------------------------------
  localparam logic [7:0]  VBLANK_GAP  = 8'h10;
  localparam int          FIFO_DEPTH  = 8;

  // default pattern for truncated bits 001, index {frame,line,pixel}
  localparam logic [127:0] PAT_G  = 128'h2200_8800_0041_0014_8800_2200_0014_0041;
  localparam logic [127:0] PAT_RB = 128'h2200_8800_1100_4400_8800_2200_4400_1100;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       hs;
    logic       vs;
    logic       de;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } afd_pix_type;

  typedef struct packed {
    logic [1:0] frame;
    logic [1:0] line;
    logic [2:0] pixel;
  } afd_pos_type;

  typedef enum logic [1:0] {ALG_DEFAULT, ALG_MONO, ALG_SAT, ALG_DARK} afd_alg_type;

  localparam int PIX_W = $bits(afd_pix_type);

endpackage

// ===== core/afd_fifo.sv
// small first-in first-out buffer on the pixel path
// assumes a single clock and active-high asynchronous reset
`timescale 1ns/1ps
module afd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign wr_ready = (cnt_q != (AW+1)'(D));
  assign rd_valid = (cnt_q != '0);
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;
  assign rd_data  = mem_q[rp_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_no_overflow : assert property (@(posedge sys_clk) disable iff (sys_rst)
    cnt_q <= (AW+1)'(D)) else $error("fifo count past depth");

endmodule // afd_fifo

// ===== tb/afd_far_model.sv
// far-side model: white-balance table and display sink
// assumes a table that answers in the same cycle as its address
`timescale 1ns/1ps
module afd_far_model (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic [1:0]           stall_mode,
  input  wire afd_pkg::afd_pix_type table_addr_q,
  output afd_pkg::afd_pix_type      table_data,
  output logic                      out_ready
);
  import afd_pkg::*;

  logic [1:0] tick_q;

  // identity table, so the output stage sees exactly what the first stage left
  assign table_data = table_addr_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_q <= 2'h0;
    end else begin
      tick_q <= tick_q + 2'h1;
    end
  end

  // 0 prompt, 1 slow (one cycle in four), 2 stalled
  assign out_ready = (stall_mode == 2'h0) | ((stall_mode == 2'h1) & (tick_q == 2'h0));
endmodule // afd_far_model

// ===== tb/test_adaptive_frc_dither.sv
// self-checking bench of the dither block
// assumes first vs start gives frame index 1, identity table
`timescale 1ns/1ps
module test_adaptive_frc_dither;
  import afd_pkg::*;

  logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic        in_valid, in_ready, out_valid, out_ready;
  afd_pix_type in_pix, table_addr_q, table_data, out_pix;
  logic [1:0]  stall, mode, fr, ln;
  logic [2:0]  px, pol;
  logic        vs_prev, hs_prev;
  int          n_mismatch, check_count, acc;
  afd_pix_type exp_q[$];

  afd_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_ready(in_ready), .in_pix(in_pix),
    .table_addr_q(table_addr_q), .table_data(table_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_pix(out_pix));
  afd_far_model far (.sys_clk(sys_clk), .sys_rst(sys_rst), .stall_mode(stall),
    .table_addr_q(table_addr_q), .table_data(table_data), .out_ready(out_ready));

  always #25 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    check(n < 50, 1, "bus answer");
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rd_q, exp, what);
  endtask

  // ------------------------------------------------------------
  // pixel stream and expectation
  // ------------------------------------------------------------
  // only density 1/8, black and saturated channels are sent, so no other rank is modelled
  function automatic logic [7:0] dith(input logic [7:0] v, input logic [6:0] idx, input logic isg);
    logic [5:0] t;
    t = v[7:2];
    if ({v[1:0], v[7]} == 3'b001 && t != 6'h3F && (isg ? PAT_G[idx] : PAT_RB[idx])) t = t + 6'h1;
    return {t, 2'h0};
  endfunction

  function automatic afd_pix_type expect_pix(input afd_pix_type w);
    afd_pix_type e;
    int n;
    e = w;
    n = (mode == 2'h3) ? 2 : int'(mode != 2'h0);
    if (w.de !== pol[2]) n = 0;
    for (int i = 0; i < n; i++) begin
      e.r = dith(e.r, {fr, ln, px}, 1'b0);
      e.g = dith(e.g, {fr, ln, px}, 1'b1);
      e.b = dith(e.b, {fr, ln, px}, 1'b0);
    end
    if (mode != 2'h0) begin
      e.r[1:0] = 2'h0;
      e.g[1:0] = 2'h0;
      e.b[1:0] = 2'h0;
    end
    return e;
  endfunction

  function automatic afd_pix_type mk(input logic h, input logic v, input logic d, input logic [23:0] rgb);
    return {h ~^ pol[0], v ~^ pol[1], d ~^ pol[2], rgb};
  endfunction

  task automatic send(input afd_pix_type w);
    int n;
    n = 0;
    in_valid <= 1'b1;
    in_pix <= w;
    if (w.vs === pol[1] && !vs_prev) begin
      fr = fr + 2'h1;
      ln = 2'h0;
      px = 3'h0;
    end
    if (w.hs === pol[0] && !hs_prev) ln = ln + 2'h1;
    vs_prev = (w.vs === pol[1]);
    hs_prev = (w.hs === pol[0]);
    exp_q.push_back(expect_pix(w));
    if (w.de === pol[2]) px = px + 3'h1;
    @(posedge sys_clk);
    while (in_ready !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    check(exp_q.size(), 0, "drain");
  endtask

  // lines of 8 pixels; last pixel black or white
  task automatic frames(input int nf);
    send(mk(1'b0, 1'b0, 1'b0, 24'h0));
    for (int f = 0; f < nf; f++) begin
      send(mk(1'b0, 1'b1, 1'b0, 24'h5A5A5A));
      for (int l = 0; l < 4; l++) begin
        if (l != 0) send(mk(1'b1, 1'b0, 1'b0, 24'h123456));
        for (int p = 0; p < 8; p++)
          send(mk(1'b0, 1'b0, 1'b1, (p != 7) ? 24'h8084FC : (l[0] ? 24'hFFFFFF : 24'h0)));
      end
    end
    in_valid <= 1'b0;
    drain();
  endtask

  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check(32'(out_pix), 32'h0, "extra pixel");
      else check(32'(out_pix), 32'(exp_q.pop_front()), "pixel");
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {sys_clk, avs_read, avs_write, in_valid, vs_prev, hs_prev} = '0;
    {avs_address, avs_writedata, in_pix, stall, mode, fr, ln, px} = '0;
    pol = 3'h7;
    sys_rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(OFS_CTRL, 32'h38, "ctrl reset");
    rd_chk(OFS_STATUS, 32'h0, "status reset");
    bus(1'b1, 4'h8, 32'hFFFFFFFF);
    rd_chk(4'h8, 32'h0, "unmapped");
    bus(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    rd_chk(OFS_STATUS, 32'h0, "status read only");
    bus(1'b1, OFS_CTRL, 32'hFFFFFFFF);
    rd_chk(OFS_CTRL, 32'h3F, "ctrl width");
    // modes none, pre, post, both, then pre with active-low timing
    for (int m = 0; m < 5; m++) begin
      mode = (m == 4) ? 2'h1 : m[1:0];
      pol = (m == 4) ? 3'h0 : 3'h7;
      stall <= (m == 2 || m == 3) ? 2'h1 : 2'h0;
      bus(1'b1, OFS_CTRL, {26'h0, pol, 1'b0, mode});
      rd_chk(OFS_CTRL, {26'h0, pol, 1'b0, mode}, "ctrl");
      frames(4);
    end
    // fill the buffer against a stalled display
    stall <= 2'h2;
    in_pix <= mk(1'b0, 1'b0, 1'b0, 24'h00FF00);
    in_valid <= 1'b1;
    acc = 0;
    for (int i = 0; i < 14; i++) begin
      @(posedge sys_clk);
      if (in_ready === 1'b1) begin
        acc++;
        exp_q.push_back(expect_pix(in_pix));
      end
    end
    in_valid <= 1'b0;
    check(in_ready, 32'h0, "full refuses");
    check(acc >= 8 && acc <= 10, 1, "fill depth");
    rd_chk(OFS_STATUS, {24'h0, 1'b1, fr, ln, px}, "status busy");
    stall <= 2'h0;
    drain();
    report_and_stop();
  end

  initial begin
    #(50 * 40000);
    n_mismatch++;
    report_and_stop();
  end
endmodule // test_adaptive_frc_dither
